// ---- rtl/bcc_pkg.sv ----
// shared types and constants for the battery charge-control block
package bcc_pkg;

  // measurement scaling
  localparam logic [7:0]  SOC_FULL   = 8'h80;   // relative soc, 128 = 100 %
  localparam logic [7:0]  PCT_FULL   = 8'h64;   // percent, 100 = 100 %
  localparam logic [15:0] TEMP_SCALE = 16'h000a; // coded temp per degree
  localparam logic [15:0] TEMP_OFFS  = 16'h00c8; // coded value at 0 degrees
  localparam logic [15:0] PEAK_RST   = 16'h0000; // peak record after reset
  localparam logic [7:0]  CNT_RST    = 8'h00;    // counter reset value
  localparam logic [7:0]  ONE8       = 8'h01;    // counter step

  // stored thresholds, read from the parameter store
  typedef struct packed {
    logic [15:0] full_charge_current;
    logic [15:0] trickle_charge_current;
    logic [15:0] charge_high_temp_limit;
    logic [15:0] charge_low_temp_limit;
    logic [15:0] normal_charge_voltage;
    logic [15:0] charge_done_voltage;
    logic [7:0]  full_flag_clear_level;
    logic [7:0]  empty_flag_clear_level;
    logic [15:0] discharge_high_temp_limit;
    logic [7:0]  temp_end_soc_value;
    logic [7:0]  end_temp_rise_step;
    logic [7:0]  end_volt_drop_step;
    logic [7:0]  overcharge_current_ceiling;
    logic [15:0] volt_drop_min_current;
    logic [7:0]  soc_ceiling;
    logic [7:0]  end_check_holdoff;
    logic [7:0]  end_sample_interval;
    logic [15:0] precharge_nominal_current;
    logic [15:0] precharge_current_ceiling;
    logic [15:0] precharge_temp_limit;
    logic [15:0] precharge_pack_volt_limit;
    logic [15:0] alarm_release_voltage;
    logic [7:0]  soc_error_clamp_range;
  } bcc_cfg_t;

  // one set of converted measurements
  typedef struct packed {
    logic        valid;     // one-cycle strobe per period
    logic [15:0] temp_int;  // coded internal temperature
    logic [15:0] temp_ext;  // coded external temperature
    logic        ext_sel;   // use the external sensor
    logic [15:0] pack_mv;   // pack voltage
    logic [15:0] cur_ma;    // charge current, signed
    logic [7:0]  soc_rel;   // relative soc, 128 = 100 %
    logic [7:0]  rem_pct;   // remaining capacity, 100 = 100 %
    logic [7:0]  soc_err;   // raw soc error
  } bcc_meas_t;

  // charge sequence
  typedef enum logic [1:0] {
    CHG_IDLE  = 2'b00,
    CHG_HOLD  = 2'b01,
    CHG_WATCH = 2'b11,
    CHG_DONE  = 2'b10
  } bcc_chg_t;

  // temperature in whole degrees to coded form
  function automatic logic [15:0] bcc_code(input logic [15:0] deg);
    bcc_code = 16'(deg * TEMP_SCALE + TEMP_OFFS);
  endfunction

endpackage

// ---- rtl/bcc_core.sv ----
// charge-control decision logic of a nickel battery manager
// Summary of operation
// RQ1: charging over high limit: trickle, done voltage
// RQ2: temperatures coded as celsius times ten plus 200
// RQ3: charging under low limit: trickle, done voltage
// RQ4: discharging over limit: trickle, done voltage
// RQ5: full flag clears below clear level
// RQ6: empty flag clears above clear level
// RQ7: temperature end loads stored soc value
// RQ8: temperature rise per sample ends charge
// RQ9: voltage drop per sample ends charge
// RQ10: voltage drop checked only at or above minimum current
// RQ11: overcharge checked only at or below current ceiling
// RQ12: reported soc clamped to stored ceiling; the temperature end load of RQ7 is not clamped
// RQ13: keep highest temperature of both sensors
// RQ14: hold off end checks after charge start
// RQ15: end samples spaced by stored period count
// RQ16: precharge below precharge temperature
// RQ17: precharge below precharge pack voltage
// RQ18: alarm cleared by pack voltage threshold
// RQ19: soc error zero inside stored range
// RQ20: full current broadcast and readable
// RQ21: charge complete requests done voltage
// RQ22: charger delivers trickle when halted
// RQ23: everything evaluated once per measurement period; charger stop, outside sets and peak writes act at once
`timescale 1ns/1ps
module bcc_core (
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  input  wire bcc_pkg::bcc_cfg_t  cfg_i,
  input  wire bcc_pkg::bcc_meas_t meas_i,
  input  wire logic              charging_i,
  input  wire logic              discharging_i,
  input  wire logic              empty_set_i,
  input  wire logic              alarm_set_i,
  input  wire logic              peak_wr_i,
  input  wire logic [15:0]       peak_wdata_i,
  output logic [15:0]            req_current_o,
  output logic [15:0]            req_voltage_o,
  output logic [15:0]            full_current_o,
  output logic                   full_flag_o,
  output logic                   empty_flag_o,
  output logic                   alarm_o,
  output logic                   precharge_o,
  output logic                   eoc_temp_o,
  output logic                   eoc_volt_o,
  output logic                   eoc_over_o,
  output logic                   soc_load_o,
  output logic [7:0]             soc_o,
  output logic [7:0]             soc_err_o,
  output logic [15:0]            peak_temp_o,
  output logic [1:0]             chg_state_o
);
  import bcc_pkg::*;

  // whole state of the block
  typedef struct packed {
    bcc_chg_t    st;        // charge sequence
    logic [7:0]  per_cnt;   // periods since last sample
    logic [7:0]  hold_cnt;  // samples since charge start
    logic [15:0] prev_t;    // temperature at last sample
    logic [15:0] prev_v;    // pack voltage at last sample
    logic [15:0] peak;      // highest coded temperature
    logic        full;      // fully charged flag
    logic        empty;     // fully discharged flag
    logic        alarm;     // terminate charge alarm
    logic        pre;       // precharge selected
    logic        e_temp;    // temperature end seen
    logic        e_volt;    // voltage drop end seen
    logic        e_over;    // overcharge end seen
    logic        soc_ld;    // soc load pulse
    logic [7:0]  soc;       // reported soc
    logic [7:0]  err;       // reported soc error
    logic [15:0] req_i;     // requested current
    logic [15:0] req_v;     // requested voltage
  } bcc_state_t;

  bcc_state_t s_q;          // registered state
  bcc_state_t s_d;          // next state

  // working terms, all driven by the process below
  logic [15:0] temp;        // temperature in use
  logic [15:0] hi_tmp;      // larger of both sensors
  logic        sample;      // end-detection sample this period
  logic [16:0] rise;        // temperature rise since sample
  logic [16:0] drop;        // voltage drop since sample
  logic        hot_cold;    // temperature outside limits
  logic        dv_ok;       // current high enough for drop test
  logic        ov_ok;       // current low enough for overcharge
  logic        end_t;       // temperature end condition
  logic        end_v;       // voltage drop end condition
  logic        end_o;       // overcharge end condition
  logic [7:0]  span;        // sample spacing, zero read as one

  // next-state logic; measurement decisions wait for the period strobe, charger stop, outside sets and peak writes do not
  always_comb begin
    s_d      = s_q;
    s_d.soc_ld = 1'b0;
    temp     = meas_i.ext_sel ? meas_i.temp_ext : meas_i.temp_int;
    hi_tmp   = (meas_i.temp_ext > meas_i.temp_int) ?
               meas_i.temp_ext : meas_i.temp_int;
    span     = (cfg_i.end_sample_interval == CNT_RST) ?
               ONE8 : cfg_i.end_sample_interval;
    sample   = meas_i.valid && (8'(s_q.per_cnt + ONE8) >= span); // RQ15
    // signed difference against the stored sample, in coded units
    rise     = 17'({1'b0, temp} - {1'b0, s_q.prev_t}); // RQ2
    drop     = 17'({1'b0, s_q.prev_v} - {1'b0, meas_i.pack_mv});
    dv_ok    = $signed(meas_i.cur_ma) >=
               $signed(cfg_i.volt_drop_min_current); // RQ10
    ov_ok    = $signed(meas_i.cur_ma) <=
               $signed({8'h00, cfg_i.overcharge_current_ceiling}); // RQ11
    // a negative difference shows as a set top bit and never ends charge
    end_t    = !rise[16] && (rise[15:0] >=
               {8'h00, cfg_i.end_temp_rise_step}); // RQ8
    end_v    = dv_ok && !drop[16] && (drop[15:0] >=
               {8'h00, cfg_i.end_volt_drop_step}); // RQ9 RQ10
    end_o    = ov_ok && (meas_i.soc_rel >= cfg_i.soc_ceiling); // RQ11
    hot_cold = (charging_i &&
                (temp > cfg_i.charge_high_temp_limit || // RQ1
                 temp < cfg_i.charge_low_temp_limit)) || // RQ3
               (discharging_i &&
                temp > cfg_i.discharge_high_temp_limit); // RQ4

    if (meas_i.valid) begin // RQ23
      // period counter restarts at every sample
      s_d.per_cnt = sample ? CNT_RST : 8'(s_q.per_cnt + ONE8); // RQ15

      // peak record follows either sensor upward
      if (hi_tmp > s_q.peak) begin
        s_d.peak = hi_tmp; // RQ13
      end

      // precharge by cold pack or low pack voltage
      s_d.pre = charging_i &&
                (temp < cfg_i.precharge_temp_limit || // RQ16
                 meas_i.pack_mv < cfg_i.precharge_pack_volt_limit); // RQ17

      // reported soc clamped to the ceiling here; the temperature end load below is not clamped
      s_d.soc = (meas_i.soc_rel > cfg_i.soc_ceiling) ?
                cfg_i.soc_ceiling : meas_i.soc_rel; // RQ12

      // soc error forced to zero inside the clamp range
      s_d.err = (meas_i.soc_rel <= cfg_i.soc_error_clamp_range) ?
                8'h00 : meas_i.soc_err; // RQ19

      // flags clear on level; a set in the same cycle wins below
      if (meas_i.rem_pct < cfg_i.full_flag_clear_level) begin
        s_d.full = 1'b0; // RQ5
      end
      if (meas_i.rem_pct > cfg_i.empty_flag_clear_level) begin
        s_d.empty = 1'b0; // RQ6
      end
      if (meas_i.pack_mv < cfg_i.alarm_release_voltage) begin
        s_d.alarm = 1'b0; // RQ18
      end
    end

    // charge sequence
    unique case (s_q.st)
      CHG_IDLE: begin
        // start of charge: reference sample taken now
        if (charging_i && meas_i.valid) begin
          s_d.st       = CHG_HOLD;
          s_d.hold_cnt = CNT_RST;
          s_d.per_cnt  = CNT_RST;
          s_d.prev_t   = temp;
          s_d.prev_v   = meas_i.pack_mv;
          s_d.e_temp   = 1'b0;
          s_d.e_volt   = 1'b0;
          s_d.e_over   = 1'b0;
        end
      end
      CHG_HOLD: begin
        // wait out the hold-off before any end test
        if (!charging_i) begin
          s_d.st = CHG_IDLE;
        end else if (sample) begin
          s_d.prev_t   = temp;
          s_d.prev_v   = meas_i.pack_mv;
          s_d.hold_cnt = 8'(s_q.hold_cnt + ONE8);
          if (8'(s_q.hold_cnt + ONE8) >= cfg_i.end_check_holdoff) begin
            s_d.st = CHG_WATCH; // RQ14
          end
        end
      end
      CHG_WATCH: begin
        // end tests once per sample, full flag stops further checks
        if (!charging_i) begin
          s_d.st = CHG_IDLE;
        end else if (sample) begin
          s_d.prev_t = temp;
          s_d.prev_v = meas_i.pack_mv;
          if (!s_q.full && (end_t || end_v || end_o)) begin // RQ5
            s_d.st     = CHG_DONE;
            s_d.full   = 1'b1;
            s_d.e_temp = end_t;
            s_d.e_volt = end_v;
            s_d.e_over = end_o;
            if (end_t) begin
              s_d.soc    = cfg_i.temp_end_soc_value; // RQ7
              s_d.soc_ld = 1'b1; // RQ7
            end
          end
        end
      end
      CHG_DONE: begin
        // hold done until the charger stops
        if (!charging_i) begin
          s_d.st = CHG_IDLE;
        end
      end
    endcase

    // outside events set over any clear in the same cycle
    if (empty_set_i) begin
      s_d.empty = 1'b1;
    end
    if (alarm_set_i) begin
      s_d.alarm = 1'b1;
    end
    // software load of the peak record
    if (peak_wr_i) begin
      s_d.peak = peak_wdata_i;
    end

    // requested current and voltage, refreshed each period
    if (meas_i.valid) begin // RQ23
      if (s_d.st == CHG_DONE) begin
        // complete: trickle current and done voltage
        s_d.req_i = cfg_i.trickle_charge_current;
        s_d.req_v = cfg_i.charge_done_voltage; // RQ21
      end else if (hot_cold) begin
        // temperature halt; charger is left with trickle only
        s_d.req_i = cfg_i.trickle_charge_current; // RQ1 RQ3 RQ4 RQ22
        s_d.req_v = cfg_i.charge_done_voltage; // RQ1 RQ3 RQ4
      end else if (s_d.pre) begin
        // precharge current never above its ceiling
        s_d.req_i = (cfg_i.precharge_nominal_current >
                     cfg_i.precharge_current_ceiling) ?
                    cfg_i.precharge_current_ceiling :
                    cfg_i.precharge_nominal_current; // RQ16 RQ17
        s_d.req_v = cfg_i.normal_charge_voltage;
      end else begin
        // normal charge
        s_d.req_i = cfg_i.full_charge_current; // RQ20
        s_d.req_v = cfg_i.normal_charge_voltage;
      end
    end
  end

  // single state register, synchronous active-low reset
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s_q.st       <= CHG_IDLE;
      s_q.per_cnt  <= CNT_RST;
      s_q.hold_cnt <= CNT_RST;
      s_q.prev_t   <= 16'h0000;
      s_q.prev_v   <= 16'h0000;
      s_q.peak     <= PEAK_RST;
      s_q.full     <= 1'b0;
      s_q.empty    <= 1'b0;
      s_q.alarm    <= 1'b0;
      s_q.pre      <= 1'b0;
      s_q.e_temp   <= 1'b0;
      s_q.e_volt   <= 1'b0;
      s_q.e_over   <= 1'b0;
      s_q.soc_ld   <= 1'b0;
      s_q.soc      <= 8'h00;
      s_q.err      <= 8'h00;
      s_q.req_i    <= 16'h0000;
      s_q.req_v    <= 16'h0000;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register, except full_current_o taken from cfg_i
  assign req_current_o  = s_q.req_i;
  assign req_voltage_o  = s_q.req_v;
  // full current is offered to charger and host alike
  assign full_current_o = cfg_i.full_charge_current; // RQ20
  assign full_flag_o    = s_q.full;
  assign empty_flag_o   = s_q.empty;
  assign alarm_o        = s_q.alarm;
  assign precharge_o    = s_q.pre;
  assign eoc_temp_o     = s_q.e_temp;
  assign eoc_volt_o     = s_q.e_volt;
  assign eoc_over_o     = s_q.e_over;
  assign soc_load_o     = s_q.soc_ld;
  assign soc_o          = s_q.soc;
  assign soc_err_o      = s_q.err;
  assign peak_temp_o    = s_q.peak;
  assign chg_state_o    = s_q.st;

endmodule // bcc_core

// ---- tb/bcc_charger_model.sv ----
// behavioural charger on the far side, follows the requested current and voltage
`timescale 1ns/1ps
module bcc_charger_model (
  input  wire logic [15:0] req_current_i,
  input  wire logic [15:0] req_voltage_i,
  output logic [15:0]      dlv_current_o,
  output logic [15:0]      dlv_voltage_o
);
  // delivers exactly what is asked, so a trickle request gives the trickle current
  assign dlv_current_o = req_current_i;
  // voltage follows too; a real charger would ramp, this one settles at once
  assign dlv_voltage_o = req_voltage_i;
endmodule // bcc_charger_model

// ---- tb/bcc_core_sva.sv ----
// checker for the charge-control decision logic, bound to its ports
`timescale 1ns/1ps
module bcc_core_sva (
  input wire logic              clk_i,
  input wire logic              nrst_i,
  input wire bcc_pkg::bcc_cfg_t  cfg_i,
  input wire bcc_pkg::bcc_meas_t meas_i,
  input wire logic              charging_i,
  input wire logic              discharging_i,
  input wire logic              peak_wr_i,
  input wire logic [15:0]       req_current_o,
  input wire logic [15:0]       req_voltage_o,
  input wire logic [15:0]       full_current_o,
  input wire logic              full_flag_o,
  input wire logic              empty_flag_o,
  input wire logic              alarm_o,
  input wire logic              eoc_temp_o,
  input wire logic              eoc_volt_o,
  input wire logic              eoc_over_o,
  input wire logic              soc_load_o,
  input wire logic [7:0]        soc_o,
  input wire logic [7:0]        soc_err_o,
  input wire logic [15:0]       peak_temp_o
);
  import bcc_pkg::*;
  logic [15:0] tsel; // temperature the limits are compared with
  assign tsel = meas_i.ext_sel ? meas_i.temp_ext : meas_i.temp_int;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // a measurement taken while charging and too hot
  sequence s_chg_hot;
    meas_i.valid && charging_i && (tsel > cfg_i.charge_high_temp_limit);
  endsequence
  // trickle request pair, the outcome of every halt
  sequence s_trickle;
    (req_current_o == cfg_i.trickle_charge_current) && (req_voltage_o == cfg_i.charge_done_voltage);
  endsequence
  chg_hot_a: assert property (s_chg_hot |=> s_trickle) else $error("hot charge not trickled");
  chg_cold_a: assert property (meas_i.valid && charging_i && tsel < cfg_i.charge_low_temp_limit
    |=> s_trickle) else $error("cold charge not trickled");
  dis_hot_a: assert property (meas_i.valid && discharging_i && tsel > cfg_i.discharge_high_temp_limit
    |=> s_trickle) else $error("hot discharge not trickled");
  full_clr_a: assert property ($fell(full_flag_o) |-> $past(meas_i.valid)
    && $past(meas_i.rem_pct) < cfg_i.full_flag_clear_level) else $error("full flag cleared early");
  empty_clr_a: assert property ($fell(empty_flag_o) |-> $past(meas_i.valid)
    && $past(meas_i.rem_pct) > cfg_i.empty_flag_clear_level) else $error("empty flag cleared early");
  alarm_clr_a: assert property ($fell(alarm_o) |-> $past(meas_i.valid)
    && $past(meas_i.pack_mv) < cfg_i.alarm_release_voltage) else $error("alarm cleared early");
  soc_load_a: assert property (soc_load_o |-> soc_o == cfg_i.temp_end_soc_value && eoc_temp_o)
    else $error("soc load value wrong");
  soc_clamp_a: assert property (!soc_load_o |-> soc_o <= cfg_i.soc_ceiling)
    else $error("soc above ceiling");
  peak_rise_a: assert property (meas_i.valid && !peak_wr_i |=> peak_temp_o >= $past(meas_i.temp_int)
    && peak_temp_o >= $past(meas_i.temp_ext)) else $error("peak record missed a maximum");
  err_zero_a: assert property (meas_i.valid && meas_i.soc_rel <= cfg_i.soc_error_clamp_range
    |=> soc_err_o == 8'h00) else $error("soc error not clamped");
  full_cur_a: assert property (full_current_o == cfg_i.full_charge_current)
    else $error("full current copy wrong");
  // a voltage-drop end may only come from a measurement at or above the minimum current
  volt_end_a: assert property ($rose(eoc_volt_o) |-> $past(meas_i.valid)
    && $signed($past(meas_i.cur_ma)) >= $signed(cfg_i.volt_drop_min_current))
    else $error("voltage end under minimum current");
  // an overcharge end may only come from a measurement at or under the current ceiling
  over_end_a: assert property ($rose(eoc_over_o) |-> $past(meas_i.valid)
    && $signed($past(meas_i.cur_ma)) <= $signed({8'h00, cfg_i.overcharge_current_ceiling}))
    else $error("overcharge end above current ceiling");
endmodule // bcc_core_sva
bind bcc_core bcc_core_sva u_bcc_core_sva (.clk_i, .nrst_i, .cfg_i, .meas_i, .charging_i, .discharging_i,
  .peak_wr_i, .req_current_o, .req_voltage_o, .full_current_o, .full_flag_o, .empty_flag_o, .alarm_o,
  .eoc_temp_o, .eoc_volt_o, .eoc_over_o, .soc_load_o, .soc_o, .soc_err_o, .peak_temp_o);

// ---- tb/test_bcc_core.sv ----
// self-checking testbench for the charge-control decision logic
`timescale 1ns/1ps
module test_bcc_core;
  import bcc_pkg::*;
  logic clk_i, nrst_i, charging_i, discharging_i, empty_set_i, alarm_set_i, peak_wr_i, soc_load_o;
  logic full_flag_o, empty_flag_o, alarm_o, precharge_o, eoc_temp_o, eoc_volt_o, eoc_over_o;
  logic [15:0] peak_wdata_i, req_current_o, req_voltage_o, full_current_o, peak_temp_o, dlv_cur, dlv_volt;
  logic [7:0]  soc_o, soc_err_o;
  logic [1:0]  chg_state_o;
  bcc_cfg_t    cfg;
  bcc_meas_t   m;
  int          err_count, total_checks, i;
  bcc_core u_bcc_core (.clk_i, .nrst_i, .cfg_i(cfg), .meas_i(m), .charging_i, .discharging_i, .empty_set_i,
    .alarm_set_i, .peak_wr_i, .peak_wdata_i, .req_current_o, .req_voltage_o, .full_current_o, .full_flag_o,
    .empty_flag_o, .alarm_o, .precharge_o, .eoc_temp_o, .eoc_volt_o, .eoc_over_o, .soc_load_o, .soc_o,
    .soc_err_o, .peak_temp_o, .chg_state_o);
  bcc_charger_model u_bcc_charger_model (.req_current_i(req_current_o), .req_voltage_i(req_voltage_o),
    .dlv_current_o(dlv_cur), .dlv_voltage_o(dlv_volt));
  // clock, 20 ns period
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // degrees to coded temperature
  function automatic logic [15:0] cd(input int deg);
    cd = 16'(deg * 10 + 200);
  endfunction
  // step to just after the next rising edge
  task automatic tick;
    @(posedge clk_i);
    #1;
  endtask
  task automatic wrap_up;
    if (err_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one measurement strobe, then a quiet cycle so strobes never touch
  task automatic vp;
    m.valid = 1'b1;
    tick;
    m.valid = 1'b0;
    tick;
  endtask
  // one measurement under given modes, compare the requests, then go idle
  task automatic cs(input logic c, input logic d, input logic [15:0] t, input logic [15:0] p,
                    input logic [15:0] ec, input logic [15:0] ev);
    charging_i = c;
    discharging_i = d;
    m.temp_int = t;
    m.temp_ext = t;
    m.pack_mv = p;
    vp;
    chk(req_current_o, ec);
    chk(req_voltage_o, ev);
    charging_i = 1'b0;
    discharging_i = 1'b0;
    tick;
  endtask
  // start a charge at steady readings and wait, bounded, for the watch phase
  task automatic ew;
    charging_i = 1'b1;
    m.temp_int = cd(25);
    m.temp_ext = cd(25);
    m.pack_mv = 16'd8000;
    m.cur_ma = 16'd1500;
    vp;
    vp;
    chk(chg_state_o, 2'b01);
    for (i = 0; i < 20 && chg_state_o !== 2'b11; i++) vp;
    if (chg_state_o !== 2'b11) begin
      err_count++;
      $display("BAD at %0t: watch phase not reached", $time);
      wrap_up;
    end
  endtask
  initial begin
    {nrst_i, charging_i, discharging_i, empty_set_i, alarm_set_i, peak_wr_i} = '0;
    peak_wdata_i = 16'h0000;
    m = '0;
    m.rem_pct = 8'd100;
    m.soc_rel = 8'd64;
    cfg = '0;
    cfg.full_charge_current = 16'd3500;       cfg.trickle_charge_current = 16'd100;
    cfg.charge_high_temp_limit = cd(60);      cfg.charge_low_temp_limit = cd(0);
    cfg.discharge_high_temp_limit = cd(60);   cfg.normal_charge_voltage = 16'd8400;
    cfg.charge_done_voltage = 16'd8000;       cfg.full_flag_clear_level = 8'd90;
    cfg.empty_flag_clear_level = 8'd13;       cfg.temp_end_soc_value = 8'd95;
    cfg.end_temp_rise_step = 8'd10;           cfg.end_volt_drop_step = 8'd60;
    cfg.overcharge_current_ceiling = 8'd200;  cfg.volt_drop_min_current = 16'd1000;
    cfg.soc_ceiling = 8'd128;                 cfg.end_check_holdoff = 8'd2;
    cfg.end_sample_interval = 8'd2;           cfg.precharge_nominal_current = 16'd300;
    cfg.precharge_current_ceiling = 16'd500;  cfg.precharge_temp_limit = cd(5);
    cfg.precharge_pack_volt_limit = 16'd7000; cfg.alarm_release_voltage = 16'd11000;
    cfg.soc_error_clamp_range = 8'd120;
    repeat (16) tick;
    nrst_i = 1'b1;
    tick;
    chk(chg_state_o, 2'b00);
    chk(full_current_o, 16'd3500);
    // request table, each at a limit or one step past it
    cs(1, 0, cd(60) + 1, 16'd8000, 16'd100, 16'd8000);
    chk(dlv_cur, 16'd100);
    chk(dlv_volt, 16'd8000);
    cs(1, 0, cd(60), 16'd8000, 16'd3500, 16'd8400);
    chk(precharge_o, 1'b0);
    cs(1, 0, cd(0) - 1, 16'd8000, 16'd100, 16'd8000);
    cs(0, 1, cd(60) + 1, 16'd8000, 16'd100, 16'd8000);
    cs(1, 0, cd(5) - 1, 16'd8000, 16'd300, 16'd8400);
    chk(precharge_o, 1'b1);
    cs(1, 0, cd(25), 16'd6999, 16'd300, 16'd8400);
    chk(precharge_o, 1'b1);
    // temperature rise of exactly one step ends the charge, only at a sample
    ew;
    m.temp_int = cd(25) + 10;
    m.temp_ext = cd(25) + 10;
    vp;
    chk(chg_state_o, 2'b11);
    vp;
    chk(eoc_temp_o, 1'b1);
    chk(req_voltage_o, 16'd8000);
    chk(soc_o, 8'd95);
    chk(full_flag_o, 1'b1);
    charging_i = 1'b0;
    m.rem_pct = 8'd90;
    vp;
    chk(full_flag_o, 1'b1);
    m.rem_pct = 8'd89;
    vp;
    chk(full_flag_o, 1'b0);
    // voltage drop ignored under the minimum current, taken at it
    m.rem_pct = 8'd100;
    ew;
    m.pack_mv = 16'd7940;
    m.cur_ma = 16'd999;
    vp;
    vp;
    chk(chg_state_o, 2'b11);
    m.pack_mv = 16'd7880;
    m.cur_ma = 16'd1000;
    vp;
    vp;
    chk(eoc_volt_o, 1'b1);
    charging_i = 1'b0;
    // flag release levels
    empty_set_i = 1'b1;
    alarm_set_i = 1'b1;
    tick;
    empty_set_i = 1'b0;
    alarm_set_i = 1'b0;
    m.rem_pct = 8'd13;
    m.pack_mv = 16'd11000;
    vp;
    chk(empty_flag_o, 1'b1);
    chk(alarm_o, 1'b1);
    m.rem_pct = 8'd14;
    m.pack_mv = 16'd10999;
    vp;
    chk(empty_flag_o, 1'b0);
    chk(alarm_o, 1'b0);
    // overcharge end ignored above the current ceiling, taken at it
    ew;
    m.soc_rel = 8'd128;
    m.cur_ma = 16'd201;
    vp;
    vp;
    chk(chg_state_o, 2'b11);
    m.cur_ma = 16'd200;
    vp;
    vp;
    chk(eoc_over_o, 1'b1);
    chk(req_current_o, 16'd100);
    charging_i = 1'b0;
    m.soc_rel = 8'd64;
    // peak record: write, then an unselected sensor sets a new maximum
    peak_wr_i = 1'b1;
    peak_wdata_i = 16'd100;
    tick;
    peak_wr_i = 1'b0;
    chk(peak_temp_o, 16'd100);
    m.temp_ext = 16'd600;
    vp;
    chk(peak_temp_o, 16'd600);
    // soc clamp and error clamp at the range edge
    m.soc_rel = 8'd200;
    vp;
    chk(soc_o, 8'd128);
    m.soc_rel = 8'd120;
    m.soc_err = 8'd5;
    vp;
    chk(soc_err_o, 8'h00);
    m.soc_rel = 8'd121;
    vp;
    chk(soc_err_o, 8'd5);
    // mid-run reset returns the registered record and soc to zero
    nrst_i = 1'b0;
    tick;
    nrst_i = 1'b1;
    tick;
    chk(peak_temp_o, 16'h0000);
    chk(soc_o, 8'h00);
    wrap_up;
  end
endmodule // test_bcc_core
